// ===== rtl/pmc_top.sv
// power mode sequencing, clock gating, dividers and interrupt routing
`include "pmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pmc_top
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // avalon-mm slave
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // wake and interrupt sources
  input  wire logic [8:0]  i_eint_pin,
  input  wire logic        i_periph_irq,
  // oscillator and loop
  input  wire logic        i_osc_ready,
  input  wire logic        i_pll_lock,
  output logic             o_osc_enable,
  output logic             o_pll_enable,
  output logic             o_cpu_clk_from_pll,
  // clock gating and control outputs
  output logic             o_cpu_run,
  output logic             o_pclk_en,
  output logic [7:0]       o_periph_clk_en,
  output logic             o_rtc_clk_ext,
  output logic             o_rtc_clk_en,
  output logic             o_vec_map_ram,
  output logic             o_pin_hold,
  output logic [3:0]       o_eint_irq
);

  pmc_state_t  state_reg;
  pmc_state_t  state_next;
  logic [1:0]  pwr_ctrl_reg;
  logic [7:0]  periph_en_reg;
  pmc_div_t    pclk_div_reg;
  logic [3:0]  clk_src_reg;
  logic [7:0]  eint_mode_reg;
  logic [3:0]  eint_wake_reg;
  logic [26:0] route_reg;
  logic [11:0] wake_cnt_reg;
  logic [1:0]  div_cnt_reg;
  logic        ack_reg;
  logic [8:0]  pin_s1_reg;
  logic [8:0]  pin_s2_reg;
  logic [1:0]  ana_s1_reg;
  logic [1:0]  ana_s2_reg;
  logic [3:0]  chan_lvl;
  logic [3:0]  chan_req;
  logic        req;
  logic        wr_en;
  logic        wake_done;
  logic        any_irq;
  logic        pd_wake;
  logic [31:0] rd_mux;

  // bus handshake: one wait cycle, answer at the second edge
  assign req           = i_read | i_write;
  assign o_waitrequest = req & ~ack_reg;
  assign wr_en         = i_write & ack_reg;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // two-stage synchronisers for pins and analog status
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
      ana_s1_reg <= 2'h0;
      ana_s2_reg <= 2'h0;
    end else begin
      pin_s1_reg <= i_eint_pin;
      pin_s2_reg <= pin_s1_reg;
      ana_s1_reg <= {i_pll_lock, i_osc_ready};
      ana_s2_reg <= ana_s1_reg;
    end
  end

  // pins combine in the active sense; a channel with no enabled pin
  // rests at its idle level so it never requests
  always_comb begin
    chan_lvl = ~eint_mode_reg[`PMC_POS_EINT_POL +: 4];
    for (int p = 0; p < 9; p++) begin
      if (route_reg[`PMC_POS_ROUTE_EN + p]) begin
        if (eint_mode_reg[`PMC_POS_EINT_POL + route_reg[2*p +: 2]]) begin
          chan_lvl[route_reg[2*p +: 2]] = chan_lvl[route_reg[2*p +: 2]]
                                          | pin_s2_reg[p];
        end else begin
          chan_lvl[route_reg[2*p +: 2]] = chan_lvl[route_reg[2*p +: 2]]
                                          & pin_s2_reg[p];
        end
      end
    end
  end

  // four independent detectors
  pmc_eint_if eif [4] ();

  for (genvar c = 0; c < 4; c++) begin : g_chan
    assign eif[c].level       = chan_lvl[c];
    assign eif[c].edge_mode   = eint_mode_reg[c];
    assign eif[c].active_high = eint_mode_reg[`PMC_POS_EINT_POL + c];
    assign eif[c].clr         = wr_en && i_address == `PMC_OFS_EINT_FLAG
                                && i_writedata[c];
    assign chan_req[c]        = eif[c].req;

    pmc_eint_chan u_chan (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .ch        (eif[c])
    );
  end

  assign any_irq   = i_periph_irq | (|chan_req);
  assign pd_wake   = |(chan_req & eint_wake_reg);
  assign wake_done = wake_cnt_reg == `PMC_WAKE_CYCLES
                     && ana_s2_reg[0];

  // power sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMC_RUN: begin
        if (pwr_ctrl_reg[`PMC_BIT_PDOWN]) begin
          state_next = PMC_PDOWN;
        end else if (pwr_ctrl_reg[`PMC_BIT_IDLE]) begin
          state_next = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (any_irq) begin
          state_next = PMC_RUN;
        end
      end
      PMC_PDOWN: begin
        if (pd_wake) begin
          state_next = PMC_WAKE;
        end
      end
      PMC_WAKE: begin
        if (wake_done) begin
          state_next = PMC_RUN;
        end
      end
      default: state_next = PMC_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= PMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake timer restarts on every power-down exit
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_cnt_reg <= 12'h000;
    end else if (state_reg != PMC_WAKE) begin
      wake_cnt_reg <= 12'h000;
    end else if (wake_cnt_reg != `PMC_WAKE_CYCLES) begin
      wake_cnt_reg <= wake_cnt_reg + 12'h001;
    end
  end

  // mode bits: software sets, hardware clears on wake
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwr_ctrl_reg <= 2'h0;
    end else if (state_reg == PMC_IDLE && state_next == PMC_RUN) begin
      pwr_ctrl_reg[`PMC_BIT_IDLE] <= 1'b0;
    end else if (state_reg == PMC_WAKE && state_next == PMC_RUN) begin
      pwr_ctrl_reg <= 2'h0;
    end else if (wr_en && i_address == `PMC_OFS_PWR_CTRL) begin
      pwr_ctrl_reg <= i_writedata[1:0];
    end
  end

  // configuration registers, frozen unless written
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      periph_en_reg <= `PMC_RST_PERIPH_EN;
      pclk_div_reg  <= pmc_div_t'(`PMC_RST_PCLK_DIV);
      clk_src_reg   <= `PMC_RST_CLK_SRC;
      eint_mode_reg <= 8'h00;
      eint_wake_reg <= 4'h0;
      route_reg     <= `PMC_RST_ROUTE;
    end else if (wr_en) begin
      case (i_address)
        `PMC_OFS_PERIPH_EN:  periph_en_reg <= i_writedata[7:0];
        `PMC_OFS_PCLK_DIV:   pclk_div_reg  <= pmc_div_t'(i_writedata[1:0]);
        `PMC_OFS_CLK_SRC:    clk_src_reg   <= i_writedata[3:0];
        `PMC_OFS_EINT_MODE:  eint_mode_reg <= i_writedata[7:0];
        `PMC_OFS_EINT_WAKE:  eint_wake_reg <= i_writedata[3:0];
        `PMC_OFS_EINT_ROUTE: route_reg     <= i_writedata[26:0];
        default: ;
      endcase
    end
  end

  // peripheral clock divider, stopped in power-down
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_reg <= 2'h0;
      o_pclk_en   <= 1'b0;
    end else if (state_next == PMC_PDOWN || state_next == PMC_WAKE) begin
      div_cnt_reg <= 2'h0;
      o_pclk_en   <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
      case (pclk_div_reg)
        PMC_DIV_FULL: o_pclk_en <= 1'b1;
        PMC_DIV_HALF: o_pclk_en <= ~div_cnt_reg[0];
        default:      o_pclk_en <= div_cnt_reg == 2'h0;
      endcase
    end
  end

  // registered clock and control outputs
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpu_run          <= 1'b1;
      o_osc_enable       <= 1'b1;
      o_pll_enable       <= 1'b0;
      o_cpu_clk_from_pll <= 1'b0;
      o_periph_clk_en    <= 8'h00;
      o_rtc_clk_ext      <= 1'b0;
      o_rtc_clk_en       <= 1'b1;
      o_vec_map_ram      <= 1'b0;
      o_pin_hold         <= 1'b0;
    end else begin
      o_cpu_run    <= state_next == PMC_RUN;
      o_osc_enable <= state_next != PMC_PDOWN;
      // loop kept running through idle, dropped in power-down and the wake wait
      o_pll_enable <= clk_src_reg[`PMC_BIT_PLL_EN]
                      && state_next != PMC_PDOWN
                      && state_next != PMC_WAKE;
      o_cpu_clk_from_pll <= clk_src_reg[`PMC_BIT_PLL_EN]
                            && clk_src_reg[`PMC_BIT_PLL_CONN]
                            && ana_s2_reg[1]
                            && state_next != PMC_PDOWN
                            && state_next != PMC_WAKE;
      if (state_next == PMC_PDOWN || state_next == PMC_WAKE) begin
        o_periph_clk_en <= 8'h00;
      end else begin
        o_periph_clk_en <= periph_en_reg;
      end
      o_rtc_clk_ext <= clk_src_reg[`PMC_BIT_RTC_EXT];
      o_rtc_clk_en  <= clk_src_reg[`PMC_BIT_RTC_EXT]
                       || (state_next != PMC_PDOWN
                           && state_next != PMC_WAKE);
      o_vec_map_ram <= clk_src_reg[`PMC_BIT_VEC_RAM];
      o_pin_hold    <= state_next == PMC_PDOWN
                       || state_next == PMC_WAKE;
    end
  end

  // interrupt requests to the processor's controller
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_eint_irq <= 4'h0;
    end else begin
      o_eint_irq <= chan_req;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_address)
      `PMC_OFS_PWR_CTRL:   rd_mux[1:0]  = pwr_ctrl_reg;
      `PMC_OFS_PERIPH_EN:  rd_mux[7:0]  = periph_en_reg;
      `PMC_OFS_PCLK_DIV:   rd_mux[1:0]  = pclk_div_reg;
      `PMC_OFS_CLK_SRC:    rd_mux[3:0]  = clk_src_reg;
      `PMC_OFS_EINT_MODE:  rd_mux[7:0]  = eint_mode_reg;
      `PMC_OFS_EINT_WAKE:  rd_mux[3:0]  = eint_wake_reg;
      `PMC_OFS_EINT_FLAG:  rd_mux[3:0]  = chan_req;
      `PMC_OFS_EINT_ROUTE: rd_mux[26:0] = route_reg;
      `PMC_OFS_STATUS: begin
        rd_mux[1:0] = state_reg;
        rd_mux[`PMC_POS_STAT_PLL] = ana_s2_reg[1];
        rd_mux[`PMC_POS_STAT_OSC] = ana_s2_reg[0];
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && !ack_reg) begin
      o_readdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pmc_map.svh
// register offsets, reset values and timing counts of the power/clock block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// word addresses on the register bus
`define PMC_OFS_PWR_CTRL   4'h0
`define PMC_OFS_PERIPH_EN  4'h1
`define PMC_OFS_PCLK_DIV   4'h2
`define PMC_OFS_CLK_SRC    4'h3
`define PMC_OFS_EINT_MODE  4'h4
`define PMC_OFS_EINT_WAKE  4'h5
`define PMC_OFS_EINT_FLAG  4'h6
`define PMC_OFS_EINT_ROUTE 4'h7
`define PMC_OFS_STATUS     4'h8

// field positions
`define PMC_BIT_IDLE       0
`define PMC_BIT_PDOWN      1
`define PMC_BIT_PLL_EN     0
`define PMC_BIT_PLL_CONN   1
`define PMC_BIT_RTC_EXT    2
`define PMC_BIT_VEC_RAM    3
`define PMC_POS_EINT_POL   4
`define PMC_POS_ROUTE_EN   18
`define PMC_POS_STAT_PLL   3
`define PMC_POS_STAT_OSC   4

// reset values
`define PMC_RST_PERIPH_EN  8'hff
`define PMC_RST_PCLK_DIV   2'h0
`define PMC_RST_CLK_SRC    4'h0
`define PMC_RST_ROUTE      27'h000_0000

// oscillator settling wait after power-down, in reference clock cycles
`define PMC_WAKE_CYCLES    12'h400

`endif

// ===== rtl/pmc_pkg.sv
// types shared by the power/clock block
package pmc_pkg;

  // power sequencing states
  typedef enum logic [1:0] {
    PMC_RUN   = 2'b00,
    PMC_IDLE  = 2'b01,
    PMC_PDOWN = 2'b10,
    PMC_WAKE  = 2'b11
  } pmc_state_t;

  // peripheral clock divide select
  typedef enum logic [1:0] {
    PMC_DIV_QUARTER = 2'b00,
    PMC_DIV_FULL    = 2'b01,
    PMC_DIV_HALF    = 2'b10
  } pmc_div_t;

endpackage

// ===== rtl/pmc_eint_if.sv
// control and request signals between the block and one interrupt channel
`timescale 1ns/1ps
`default_nettype none

interface pmc_eint_if;
  logic level;
  logic edge_mode;
  logic active_high;
  logic clr;
  logic req;

  modport ctrl (output level, output edge_mode, output active_high,
                output clr, input req);
  modport chan (input level, input edge_mode, input active_high,
                input clr, output req);
endinterface

`default_nettype wire

// ===== rtl/pmc_eint_chan.sv
// one external interrupt channel: edge or level detect with sticky flag
`timescale 1ns/1ps
`default_nettype none

module pmc_eint_chan (
  // clock and reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_resetn,
  // channel link
  pmc_eint_if.chan   ch
);

  logic prev_reg;
  logic flag_reg;
  logic act;

  assign act = ch.active_high ? ch.level : ~ch.level;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= act;
    end
  end

  // edge flag is sticky; a new edge in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_reg <= 1'b0;
    end else if (ch.edge_mode && act && !prev_reg) begin
      flag_reg <= 1'b1;
    end else if (ch.clr || !ch.edge_mode) begin
      flag_reg <= 1'b0;
    end
  end

  assign ch.req = ch.edge_mode ? flag_reg : act;

endmodule

`default_nettype wire

// ===== testbench/pmc_chk.sv
// concurrent checks on the power/clock block ports
`timescale 1ns/1ps
`default_nettype none

module pmc_chk (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // observed signals
  input  wire logic       i_periph_irq,
  input  wire logic       o_osc_enable,
  input  wire logic       o_pll_enable,
  input  wire logic       o_cpu_clk_from_pll,
  input  wire logic       o_cpu_run,
  input  wire logic       o_pclk_en,
  input  wire logic [7:0] o_periph_clk_en,
  input  wire logic       o_rtc_clk_ext,
  input  wire logic       o_rtc_clk_en,
  input  wire logic       o_vec_map_ram,
  input  wire logic       o_pin_hold,
  input  wire logic [3:0] o_eint_irq
);
  logic [11:0] wcnt_reg;

  // cycles spent in the wake wait
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      wcnt_reg <= 12'h000;
    else if (o_pin_hold && o_osc_enable)
      wcnt_reg <= wcnt_reg + 12'h001;
    else
      wcnt_reg <= 12'h000;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_idle_resume:
    assert property (!o_cpu_run && !o_pin_hold && i_periph_irq |=> o_cpu_run)
    else $error("idle not left on peripheral irq");
  a_idle_cause:
    assert property ($rose(o_cpu_run) && !$past(o_pin_hold)
      |-> $past(i_periph_irq) || (|o_eint_irq))
    else $error("idle left without interrupt");
  a_idle_loop_kept:
    assert property ($fell(o_cpu_run) && !o_pin_hold
      |-> o_pll_enable == $past(o_pll_enable))
    else $error("loop changed on idle entry");
  a_pd_clocks_off:
    assert property (o_pin_hold
      |-> !o_pclk_en && o_periph_clk_en == 8'h00 && !o_cpu_run)
    else $error("clock running in power-down");
  a_pd_osc_stop:
    assert property ($rose(o_pin_hold) |-> !o_osc_enable)
    else $error("oscillator kept on in power-down");
  a_pd_frozen:
    assert property (o_pin_hold && $past(o_pin_hold)
      |-> $stable(o_vec_map_ram) && $stable(o_rtc_clk_ext))
    else $error("output changed in power-down");
  a_pd_no_run:
    assert property (!o_osc_enable |=> !o_cpu_run)
    else $error("run straight out of power-down");
  a_wake_timer:
    assert property ($rose(o_cpu_run) && $past(o_pin_hold)
      |-> wcnt_reg >= 12'h3ff)
    else $error("wake wait too short");
  a_rtc_pd_src:
    assert property (o_pin_hold |-> o_rtc_clk_en == o_rtc_clk_ext)
    else $error("rtc clock wrong in power-down");
  a_div_reset:
    assert property ($rose(i_resetn)
      |=> o_pclk_en ##1 !o_pclk_en [*3] ##1 o_pclk_en)
    else $error("divider not quarter after reset");
  a_pll_source:
    assert property (o_cpu_clk_from_pll |-> o_pll_enable)
    else $error("cpu clock from stopped loop");

  c_idle: cover property ($fell(o_cpu_run) && !o_pin_hold);
  c_pdown: cover property ($rose(o_pin_hold));
  c_wake: cover property ($rose(o_cpu_run) && $past(o_pin_hold));
endmodule

`default_nettype wire

// ===== testbench/pmc_osc_model.sv
// oscillator and loop model on the far side of the power/clock block
`timescale 1ns/1ps
`default_nettype none

module pmc_osc_model #(
  parameter int OSC_DLY = 1500,
  parameter int PLL_DLY = 20
) (
  // clock
  input  wire logic i_ref_clk,
  // enables from the block
  input  wire logic i_osc_enable,
  input  wire logic i_pll_enable,
  // status to the block
  output logic      o_osc_ready,
  output logic      o_pll_lock
);
  int osc_cnt;
  int pll_cnt;

  // a restarted oscillator is slow to become usable
  always_ff @(posedge i_ref_clk) begin
    if (i_osc_enable !== 1'b1)
      osc_cnt <= 0;
    else if (osc_cnt < OSC_DLY)
      osc_cnt <= osc_cnt + 1;
  end

  // lock is lost at once when the loop is stopped
  always_ff @(posedge i_ref_clk) begin
    if (i_pll_enable !== 1'b1)
      pll_cnt <= 0;
    else if (pll_cnt < PLL_DLY)
      pll_cnt <= pll_cnt + 1;
  end

  assign o_osc_ready = (osc_cnt >= OSC_DLY);
  assign o_pll_lock  = (pll_cnt >= PLL_DLY);
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the power/clock block
`include "pmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pmc_pkg::*;
  typedef struct {
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } pmc_row_t;
  logic        i_ref_clk, i_resetn, i_read, i_write, i_periph_irq;
  logic        i_osc_ready, i_pll_lock, o_waitrequest, o_osc_enable;
  logic        o_pll_enable, o_cpu_clk_from_pll, o_cpu_run, o_pclk_en;
  logic        o_rtc_clk_ext, o_rtc_clk_en, o_vec_map_ram, o_pin_hold;
  logic [3:0]  i_address, o_eint_irq;
  logic [7:0]  o_periph_clk_en;
  logic [8:0]  i_eint_pin;
  logic [31:0] i_writedata, o_readdata, rd;
  int          error_cnt, n_checks, cyc, k, n;
  pmc_row_t    rows [5];

  pmc_top i_pmc_top (.i_ref_clk, .i_resetn, .i_address, .i_read, .i_write,
    .i_writedata, .o_readdata, .o_waitrequest, .i_eint_pin, .i_periph_irq,
    .i_osc_ready, .i_pll_lock, .o_osc_enable, .o_pll_enable,
    .o_cpu_clk_from_pll, .o_cpu_run, .o_pclk_en, .o_periph_clk_en,
    .o_rtc_clk_ext, .o_rtc_clk_en, .o_vec_map_ram, .o_pin_hold, .o_eint_irq);
  pmc_osc_model i_pmc_osc_model (.i_ref_clk, .i_osc_enable(o_osc_enable),
    .i_pll_enable(o_pll_enable), .o_osc_ready(i_osc_ready),
    .o_pll_lock(i_pll_lock));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_ref_clk);
    i_address   <= a;
    i_writedata <= d;
    i_read      <= !wr;
    i_write     <= wr;
    @(negedge i_ref_clk);
    while (o_waitrequest !== 1'b0 && t < 100) begin
      @(negedge i_ref_clk);
      t++;
    end
    if (t == 100)
      error_cnt++;
    @(posedge i_ref_clk);
    rd = o_readdata;
    i_read  <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wn(input int c);
    repeat (c) @(negedge i_ref_clk);
  endtask

  task automatic pclk_count;
    n = 0;
    wn(4);
    repeat (8) begin
      @(negedge i_ref_clk);
      n += int'(o_pclk_en);
    end
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end

  initial begin
    rows[0] = '{`PMC_OFS_PERIPH_EN, 32'h0000_005a, 32'h0000_005a};
    rows[1] = '{`PMC_OFS_CLK_SRC, 32'h0000_0008, 32'h0000_0008};
    rows[2] = '{`PMC_OFS_EINT_MODE, 32'h0000_0033, 32'h0000_0033};
    rows[3] = '{`PMC_OFS_PCLK_DIV, 32'h0000_0001, 32'h0000_0001};
    rows[4] = '{4'hf, 32'hffff_ffff, 32'h0000_0000};
    {i_resetn, i_read, i_write, i_periph_irq} = 4'h0;
    i_address = 4'h0;
    i_writedata = 32'h0000_0000;
    i_eint_pin = 9'h004;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    pclk_count();
    chk(n, 2);
    chk(o_periph_clk_en, 8'hff);
    bus(0, `PMC_OFS_PCLK_DIV, 0);
    chk(rd, 0);
    $display("reset test done");
    for (k = 0; k < 5; k++) begin
      bus(1, rows[k].a, rows[k].d);
      bus(0, rows[k].a, 0);
      chk(rd, rows[k].e);
    end
    chk(o_periph_clk_en, 8'h5a);
    chk(o_vec_map_ram, 1);
    $display("table test done");
    for (k = 1; k < 4; k++) begin
      if (k > 1)
        bus(1, `PMC_OFS_PCLK_DIV, k);
      pclk_count();
      chk(n, (k == 1) ? 8 : (k == 2) ? 4 : 2);
    end
    bus(1, `PMC_OFS_CLK_SRC, 3);
    wn(40);
    chk(o_cpu_clk_from_pll, 1);
    bus(1, `PMC_OFS_CLK_SRC, 1);
    wn(3);
    chk(o_cpu_clk_from_pll, 0);
    $display("clock test done");
    bus(1, `PMC_OFS_EINT_ROUTE, 32'h001c_0024);
    bus(1, `PMC_OFS_EINT_WAKE, 2);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h000;
    wn(6);
    chk(o_eint_irq, 4'h4);
    bus(1, `PMC_OFS_PWR_CTRL, 1);
    wn(4);
    chk(o_cpu_run, 1);
    bus(0, `PMC_OFS_PWR_CTRL, 0);
    chk(rd[1:0], 0);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h004;
    wn(6);
    bus(1, `PMC_OFS_PWR_CTRL, 1);
    wn(20);
    chk({o_cpu_run, o_pll_enable, o_periph_clk_en}, 10'h15a);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h104;
    wn(8);
    chk(o_cpu_run, 0);
    bus(1, `PMC_OFS_PWR_CTRL, 1);
    @(posedge i_ref_clk);
    i_periph_irq <= 1'b1;
    @(posedge i_ref_clk);
    i_periph_irq <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_cpu_run, 1);
    bus(0, `PMC_OFS_PWR_CTRL, 0);
    chk(rd[1:0], 0);
    bus(1, `PMC_OFS_PWR_CTRL, 1);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h005;
    wn(8);
    chk({o_cpu_run, o_eint_irq}, 5'h11);
    bus(1, `PMC_OFS_EINT_FLAG, 1);
    wn(2);
    chk(o_eint_irq, 4'h0);
    $display("idle test done");
    bus(1, `PMC_OFS_CLK_SRC, 32'h0000_000d);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h004;
    bus(1, `PMC_OFS_PWR_CTRL, 2);
    wn(3);
    chk({o_osc_enable, o_pll_enable, o_pin_hold, o_rtc_clk_en}, 3);
    chk(o_rtc_clk_ext, 1);
    @(posedge i_ref_clk);
    i_eint_pin <= 9'h005;
    i_periph_irq <= 1'b1;
    wn(10);
    chk({o_osc_enable, o_cpu_run, o_vec_map_ram}, 1);
    @(posedge i_ref_clk);
    i_periph_irq <= 1'b0;
    i_eint_pin <= 9'h007;
    wn(8);
    chk({o_osc_enable, o_cpu_run}, 2);
    wn(1000);
    chk(o_cpu_run, 0);
    bus(0, `PMC_OFS_STATUS, 0);
    chk(rd[4:0], 5'h03);
    k = 0;
    while (o_cpu_run !== 1'b1 && k < 1000) begin
      @(negedge i_ref_clk);
      k++;
    end
    chk({o_cpu_run, k > 400}, 3);
    bus(0, `PMC_OFS_PWR_CTRL, 0);
    chk(rd[1:0], 0);
    $display("power-down test done");
    give_verdict;
  end
endmodule

bind pmc_top pmc_chk i_pmc_chk (.i_ref_clk, .i_resetn, .i_periph_irq,
  .o_osc_enable, .o_pll_enable, .o_cpu_clk_from_pll, .o_cpu_run, .o_pclk_en,
  .o_periph_clk_en, .o_rtc_clk_ext, .o_rtc_clk_en, .o_vec_map_ram,
  .o_pin_hold, .o_eint_irq);

`default_nettype wire
